// *** rtl/ledst_pkg.sv ***
// Constants and types shared by the LED connectivity self-test block
package ledst_pkg;

    // ****************************************************************
    // Register map and command codes
    // ****************************************************************
    localparam logic [7:0] REG_TEST_CMD_RES = 8'h0c;  // Test command / result register
    localparam logic [7:0] TEST_START_CODE  = 8'h01;  // Written value that starts the test
    localparam logic [7:0] RES_RESET        = 8'h00;  // Result register after reset
    localparam logic [7:0] READ_UNMAPPED    = 8'h00;  // Read value of any other index
    localparam logic [6:0] BUS_TARGET_ADDR  = 7'h4c;  // Seven-bit control bus address
    localparam int         RES_DONE_BIT     = 7;      // Result field: test finished

    // ****************************************************************
    // Test geometry and timing
    // ****************************************************************
    localparam int         NUM_PATHS         = 5;     // LED paths checked per test
    localparam logic [2:0] LAST_STEP         = 3'h4;  // Index of the final path
    localparam logic [3:0] BITS_PER_BYTE     = 4'h8;  // Serial bits per byte
    localparam logic [3:0] LAST_TX_BIT       = 4'h7;  // Last bit of a sent byte
    localparam int         CLK_PERIOD_NS     = 100;   // System clock period
    localparam int         RESULT_SETTLE_NS  = 10000; // Longest strobe-to-result time
    localparam int         RESULT_SETTLE_CYC = RESULT_SETTLE_NS / CLK_PERIOD_NS;

    // ****************************************************************
    // Types
    // ****************************************************************
    // Pin-driven test engine states
    typedef enum logic [1:0] {PT_IDLE, PT_ACK, PT_STEP, PT_FAIL} ledst_pin_t;

    // Control bus target states
    typedef enum logic [3:0] {
        BS_IDLE, BS_ADDR, BS_ADDR_ACK, BS_INDEX, BS_INDEX_ACK,
        BS_DATA, BS_DATA_ACK, BS_TX, BS_TX_ACK
    } ledst_bus_t;

    // Three-stage synchronisers for outside inputs
    typedef struct packed {
        logic [2:0] strobe;
        logic [2:0] scl;
        logic [2:0] sda;
        logic [2:0] active_low_reset_pin;
    } ledst_sync_t;

    // Whole state of the block
    typedef struct packed {
        ledst_sync_t            sy;
        logic                   strobeLvl;
        logic                   sclLvl;
        logic                   sdaLvl;
        logic                   nrstLvl;
        ledst_pin_t             pin;
        logic [2:0]             step;
        logic                   result;
        ledst_bus_t             bus;
        logic [3:0]             bitCnt;
        logic [7:0]             shift;
        logic                   rw;
        logic [7:0]             index;
        logic                   sdaOe;
        logic                   sdaOut;
        logic                   fRun;
        logic [2:0]             fStep;
        logic [NUM_PATHS-1:0]   fPass;
        logic                   fDone;
    } ledst_state_t;

endpackage

// *** rtl/ledst_self_test.sv ***
// LED connectivity self-test engine with pin and control bus access
`timescale 1ns/100ps
module ledst_self_test
    import ledst_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = BUS_TARGET_ADDR
) (
    // Clock and power-on reset
    input  wire logic                 clk_sys,
    input  wire logic                 srst,
    // Test pins
    input  wire logic                 testStrobeIn,
    output logic                      testResultOut,
    // Control bus pins, data is open drain
    input  wire logic                 sclIn,
    input  wire logic                 sdaIn,
    output logic                      sdaOut,
    output logic                      sdaOe,
    // Reset pin, clears only the bus side
    input  wire logic                 activeLowResetPinN,
    // Enable bits from the other control registers
    input  wire logic                 standbyReleaseBit,
    input  wire logic                 converterEnableBit,
    // Analog checker results
    input  wire logic                 selfCheckOk,
    input  wire logic [NUM_PATHS-1:0] ledPathOk
);

    // ****************************************************************
    // State
    // ****************************************************************
    ledst_state_t st_r;       // Registered state
    ledst_state_t st_nxt;     // Next state
    logic         startFire;  // Bus write that starts the field test
    logic         sclRise;    // Bus clock rising edge
    logic         pathSel;    // Checker result of the current pin step

    assign pathSel = ledPathOk[st_r.step];

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // Synchronisers, pin engine, bus target and field engine
    always_comb begin
        logic       strobeRise;
        logic       strobeFall;
        logic       sclFall;
        logic       busStart;
        logic       busStop;
        logic       outcome;
        logic [7:0] readVal;
        strobeRise = 1'b0;
        strobeFall = 1'b0;
        sclFall    = 1'b0;
        busStart   = 1'b0;
        busStop    = 1'b0;
        outcome    = 1'b0;
        readVal    = READ_UNMAPPED;
        startFire  = 1'b0;
        sclRise    = 1'b0;
        st_nxt     = st_r;

        // Shift the outside inputs; first stage feeds only the second
        st_nxt.sy.strobe = {st_r.sy.strobe[1:0], testStrobeIn};
        st_nxt.sy.scl    = {st_r.sy.scl[1:0], sclIn};
        st_nxt.sy.sda    = {st_r.sy.sda[1:0], sdaIn};
        st_nxt.sy.active_low_reset_pin   = {st_r.sy.active_low_reset_pin[1:0], activeLowResetPinN};
        // Accept a level once the second and third stages agree
        if (st_r.sy.strobe[1] == st_r.sy.strobe[2]) begin
            st_nxt.strobeLvl = st_r.sy.strobe[2];
        end
        if (st_r.sy.scl[1] == st_r.sy.scl[2]) begin
            st_nxt.sclLvl = st_r.sy.scl[2];
        end
        if (st_r.sy.sda[1] == st_r.sy.sda[2]) begin
            st_nxt.sdaLvl = st_r.sy.sda[2];
        end
        if (st_r.sy.active_low_reset_pin[1] == st_r.sy.active_low_reset_pin[2]) begin
            st_nxt.nrstLvl = st_r.sy.active_low_reset_pin[2];
        end
        strobeRise = st_nxt.strobeLvl & ~st_r.strobeLvl;
        strobeFall = ~st_nxt.strobeLvl & st_r.strobeLvl;
        sclRise    = st_nxt.sclLvl & ~st_r.sclLvl;
        sclFall    = ~st_nxt.sclLvl & st_r.sclLvl;
        busStart   = st_r.sclLvl & st_nxt.sclLvl & st_r.sdaLvl & ~st_nxt.sdaLvl;
        busStop    = st_r.sclLvl & st_nxt.sclLvl & ~st_r.sdaLvl & st_nxt.sdaLvl;

        // Pin engine, cleared by power-on reset only
        case (st_r.pin)
            PT_IDLE: begin
                // First strobe high asks for the self
                if (strobeRise) begin
                    st_nxt.pin = PT_ACK;
                end
            end
            PT_ACK: begin
                // Failed acknowledge blocks the pattern
                if (strobeFall && !selfCheckOk) begin
                    st_nxt.pin = PT_FAIL;
                end else if (strobeRise) begin
                    st_nxt.pin  = PT_STEP;
                    st_nxt.step = 3'h0;
                end
            end
            PT_STEP: begin
                // Each further strobe high selects the next path
                if (strobeRise && st_r.step != LAST_STEP) begin
                    st_nxt.step = st_r.step + 3'h1;
                end
                // End of the final high phase closes the
                if (strobeFall && st_r.step == LAST_STEP) begin
                    st_nxt.pin  = PT_IDLE;
                    st_nxt.step = 3'h0;
                end
            end
            PT_FAIL: begin
                // Stays here until power-on reset
                st_nxt.pin = PT_FAIL;
            end
            default: begin
                st_nxt.pin = PT_IDLE;
            end
        endcase

        // Outcome of the step in force, gated by the strobe level
        case (st_nxt.pin)
            PT_ACK:  outcome = selfCheckOk;
            PT_STEP: outcome = ledPathOk[st_nxt.step];
            default: outcome = 1'b0;
        endcase
        st_nxt.result = st_nxt.strobeLvl & outcome;

        // Read value of the selected register
        if (st_r.index == REG_TEST_CMD_RES) begin
            readVal = {st_r.fDone, 2'b00, st_r.fPass};
        end

        // Control bus target
        if (busStop || !st_r.nrstLvl) begin
            st_nxt.bus   = BS_IDLE;
            st_nxt.sdaOe = 1'b0;
        end else if (busStart) begin
            st_nxt.bus    = BS_ADDR;
            st_nxt.bitCnt = 4'h0;
            st_nxt.sdaOe  = 1'b0;
        end else begin
            case (st_r.bus)
                BS_ADDR, BS_INDEX, BS_DATA: begin
                    // Shift in MSB first on clock rise; take the data level accepted
                    // with that same rise, since our own ack release can land there
                    if (sclRise) begin
                        st_nxt.shift  = {st_r.shift[6:0], st_nxt.sdaLvl};
                        st_nxt.bitCnt = st_r.bitCnt + 4'h1;
                    end
                    // Decide on the byte after its eighth clock
                    if (sclFall && st_r.bitCnt == BITS_PER_BYTE) begin
                        st_nxt.bitCnt = 4'h0;
                        st_nxt.sdaOe  = 1'b1;
                        if (st_r.bus == BS_ADDR) begin
                            if (st_r.shift[7:1] == SLAVE_ADDR) begin
                                st_nxt.rw  = st_r.shift[0];
                                st_nxt.bus = BS_ADDR_ACK;
                            end else begin
                                st_nxt.sdaOe = 1'b0;
                                st_nxt.bus   = BS_IDLE;
                            end
                        end else if (st_r.bus == BS_INDEX) begin
                            st_nxt.index = st_r.shift;
                            st_nxt.bus   = BS_INDEX_ACK;
                        end else begin
                            st_nxt.bus = BS_DATA_ACK;
                            // Start command, only with the device enabled
                            startFire = (st_r.index == REG_TEST_CMD_RES) &&
                                        (st_r.shift == TEST_START_CODE) &&
                                        standbyReleaseBit && converterEnableBit;
                        end
                    end
                end
                BS_ADDR_ACK: begin
                    // Release ack, then receive index or send data
                    if (sclFall) begin
                        st_nxt.bitCnt = 4'h0;
                        if (st_r.rw) begin
                            st_nxt.shift = readVal;
                            st_nxt.sdaOe = ~readVal[7];
                            st_nxt.bus   = BS_TX;
                        end else begin
                            st_nxt.sdaOe = 1'b0;
                            st_nxt.bus   = BS_INDEX;
                        end
                    end
                end
                BS_INDEX_ACK, BS_DATA_ACK: begin
                    // Further data bytes rewrite the same index
                    if (sclFall) begin
                        st_nxt.sdaOe = 1'b0;
                        st_nxt.bus   = BS_DATA;
                    end
                end
                BS_TX: begin
                    // Next bit on each clock fall
                    if (sclFall) begin
                        st_nxt.bitCnt = st_r.bitCnt + 4'h1;
                        if (st_r.bitCnt == LAST_TX_BIT) begin
                            st_nxt.sdaOe = 1'b0;
                            st_nxt.bus   = BS_TX_ACK;
                        end else begin
                            st_nxt.shift = {st_r.shift[6:0], 1'b0};
                            st_nxt.sdaOe = ~st_r.shift[6];
                        end
                    end
                end
                BS_TX_ACK: begin
                    // Host ack repeats the register, no-ack ends the read
                    if (sclRise) begin
                        st_nxt.bus = st_nxt.sdaLvl ? BS_IDLE : BS_ADDR_ACK;
                    end
                end
                default: begin
                    st_nxt.bus = BS_IDLE;
                end
            endcase
        end
        st_nxt.sdaOut = 1'b0;

        // Field engine, paced by the bus clock
        if (startFire) begin
            st_nxt.fRun  = 1'b1;
            st_nxt.fStep = 3'h0;
            st_nxt.fPass = '0;
            st_nxt.fDone = 1'b0;
        end else if (st_r.fRun && sclRise) begin
            st_nxt.fPass[st_r.fStep] = ledPathOk[st_r.fStep];
            if (st_r.fStep == LAST_STEP) begin
                st_nxt.fRun  = 1'b0;
                st_nxt.fDone = 1'b1;
            end else begin
                st_nxt.fStep = st_r.fStep + 3'h1;
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Power-on reset puts every engine in idle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign testResultOut = st_r.result;
    assign sdaOe         = st_r.sdaOe;
    assign sdaOut        = st_r.sdaOut;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    localparam int SettleMax = RESULT_SETTLE_CYC;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_strobeUp;
        $rose(st_r.strobeLvl);
    endsequence

    property p_lowWhenStrobeLow;
        (!testStrobeIn)[*5] |-> !testResultOut;
    endproperty
    a_lowWhenStrobeLow: assert property (p_lowWhenStrobeLow)
        else $error("result high while strobe low");

    property p_settle;
        $rose(testStrobeIn) ##1 testStrobeIn[*4] |-> ##[0:SettleMax] st_r.strobeLvl;
    endproperty
    a_settle: assert property (p_settle)
        else $error("strobe not seen within settling time");

    property p_ackResult;
        s_strobeUp ##0 (st_r.pin == PT_ACK) |-> testResultOut == $past(selfCheckOk);
    endproperty
    a_ackResult: assert property (p_ackResult)
        else $error("acknowledge does not follow self-check");

    property p_stepResult;
        st_r.strobeLvl && st_r.pin == PT_STEP && $past(st_r.pin == PT_STEP)
            && $stable(st_r.step) |-> testResultOut == $past(pathSel);
    endproperty
    a_stepResult: assert property (p_stepResult)
        else $error("step result does not follow path check");

    property p_stepAdvance;
        s_strobeUp ##0 $past(st_r.pin == PT_STEP && st_r.step != LAST_STEP)
            |-> st_r.step == $past(st_r.step) + 3'h1;
    endproperty
    a_stepAdvance: assert property (p_stepAdvance)
        else $error("step counter did not advance");

    property p_endIdle;
        $fell(st_r.strobeLvl) && $past(st_r.pin == PT_STEP && st_r.step == LAST_STEP)
            |-> st_r.pin == PT_IDLE;
    endproperty
    a_endIdle: assert property (p_endIdle)
        else $error("engine not idle after final pulse");

    property p_fieldStart;
        startFire |=> st_r.fRun && st_r.fStep == 3'h0 && !st_r.fDone;
    endproperty
    a_fieldStart: assert property (p_fieldStart)
        else $error("field test did not start");

    property p_fieldPace;
        st_r.fRun && !sclRise && !startFire |=> $stable(st_r.fStep) && st_r.fRun;
    endproperty
    a_fieldPace: assert property (p_fieldPace)
        else $error("field test stepped without bus clock");

    property p_resultHold;
        st_r.fDone && !startFire |=> st_r.fDone && $stable(st_r.fPass);
    endproperty
    a_resultHold: assert property (p_resultHold)
        else $error("field result changed without restart");

    property p_readBack;
        st_r.bus == BS_TX && $past(st_r.bus == BS_ADDR_ACK)
            && st_r.index == REG_TEST_CMD_RES
            |-> st_r.shift == {st_r.fDone, 2'b00, st_r.fPass};
    endproperty
    a_readBack: assert property (p_readBack)
        else $error("read data is not the field result");

endmodule

// *** dv/ledst_host_model.sv ***
// Tester and bus host model for the LED self-test block
`timescale 1ns/100ps
module ledst_host_model
    import ledst_pkg::*;
(
    // Clock
    input  wire logic clk_sys,
    // Test pins
    output logic      testStrobeIn,
    input  wire logic testResultOut,
    // Control bus pins
    output logic      sclIn,
    output logic      sdaIn,
    input  wire logic sdaOut,
    input  wire logic sdaOe
);
    // ****************************************************************
    // Pin levels
    // ****************************************************************
    localparam int PHASE_CYC  = 2000;   // Strobe phase of 200 us
    localparam int SETTLE_CYC = 100;    // Result settling bound of 10 us
    logic          sdaDrv;              // Host side of the data line

    // Idle levels from time zero
    initial begin
        testStrobeIn = 1'b0;
        sclIn = 1'b1;
        sdaDrv = 1'b1;
    end

    // Pulled-up wire, low while either party pulls it
    assign sdaIn = sdaDrv & ~(sdaOe & ~sdaOut);

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Wait edges, then step just past the last one
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // One strobe pulse, result sampled after settling in each phase
    task automatic pulse(output logic hi, output logic lo);
        testStrobeIn = 1'b1; // One high phase selects one step
        tick(SETTLE_CYC);
        hi = testResultOut;
        tick(PHASE_CYC - SETTLE_CYC);
        testStrobeIn = 1'b0;
        tick(SETTLE_CYC);
        lo = testResultOut;
        tick(PHASE_CYC - SETTLE_CYC);
    endtask

    // One serial bit of 800 ns, wire sampled at the end of the high phase
    // Rate is fixed here; the device misses any clock phase shorter than two system clocks
    task automatic send_bit(input logic b, output logic s);
        tick(1);
        sdaDrv = b;
        tick(3);
        sclIn = 1'b1;
        tick(4);
        s = sdaIn;
        sclIn = 1'b0;
    endtask

    // Start or repeated start, data falls while the clock is high
    task automatic start();
        tick(1);
        sdaDrv = 1'b1;
        tick(3);
        sclIn = 1'b1;
        tick(4);
        sdaDrv = 1'b0;
        tick(4);
        sclIn = 1'b0;
    endtask

    // Stop, data rises while the clock is high
    task automatic stop();
        tick(1);
        sdaDrv = 1'b0;
        tick(3);
        sclIn = 1'b1;
        tick(4);
        sdaDrv = 1'b1;
        tick(4);
    endtask

    // Eight bits MSB first, then the acknowledge bit
    task automatic xfer(input logic [7:0] tx, input logic ackIn,
                        output logic [7:0] rx, output logic ackOut);
        for (int i = 7; i >= 0; i--) begin
            send_bit(tx[i], rx[i]);
        end
        send_bit(ackIn, ackOut);
    endtask

    // Address, index, data; ack bits returned in order
    task automatic reg_write(input logic [6:0] dev, input logic [7:0] idx,
                             input logic [7:0] dat, output logic [2:0] acks);
        logic [7:0] rx;
        start();
        xfer({dev, 1'b0}, 1'b1, rx, acks[2]); // Address then index
        xfer(idx, 1'b1, rx, acks[1]);
        xfer(dat, 1'b1, rx, acks[0]);
        stop();
    endtask

    // Index write, repeated start, one byte read and not acknowledged
    task automatic reg_read(input logic [7:0] idx, output logic [7:0] dat,
                            output logic [2:0] acks);
        logic [7:0] rx;
        logic       nack;
        start();
        xfer({BUS_TARGET_ADDR, 1'b0}, 1'b1, rx, acks[2]); // Index first
        xfer(idx, 1'b1, rx, acks[1]);
        start();
        xfer({BUS_TARGET_ADDR, 1'b1}, 1'b1, rx, acks[0]);
        xfer(8'hff, 1'b1, dat, nack);
        stop();
    endtask
endmodule

// *** dv/led_connectivity_self_test_test.sv ***
// Self-checking testbench of the LED connectivity self-test block
`timescale 1ns/100ps
module led_connectivity_self_test_test
    import ledst_pkg::*;
;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    localparam int PWR_WAIT_CYC = 10000;  // Tester wait of 1 ms
    localparam int TIMEOUT_CYC  = 70000;  // Run ceiling
    logic                 clk_sys;
    logic                 srst;
    logic                 testStrobeIn;
    logic                 testResultOut;
    logic                 sclIn;
    logic                 sdaIn;
    logic                 sdaOut;
    logic                 sdaOe;
    logic                 activeLowResetPinN;
    logic                 standbyReleaseBit;
    logic                 converterEnableBit;
    logic                 selfCheckOk;
    logic [NUM_PATHS-1:0] ledPathOk;
    int                   errors;
    int                   total_checks;
    int                   cycles;

    // Device under test
    ledst_self_test i_dut (
        .clk_sys(clk_sys), .srst(srst), .testStrobeIn(testStrobeIn),
        .testResultOut(testResultOut), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .activeLowResetPinN(activeLowResetPinN),
        .standbyReleaseBit(standbyReleaseBit), .converterEnableBit(converterEnableBit),
        .selfCheckOk(selfCheckOk), .ledPathOk(ledPathOk)
    );

    // Tester and host on the far side
    ledst_host_model i_host (
        .clk_sys(clk_sys), .testStrobeIn(testStrobeIn), .testResultOut(testResultOut),
        .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe)
    );

    // Clock of 100 ns period
    initial clk_sys = 1'b0;
    always #50 clk_sys = ~clk_sys;

    // Hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYC) begin
            errors = errors + 1;
            print_verdict();
        end
    end

    // ****************************************************************
    // Common tasks
    // ****************************************************************
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic print_verdict();
        if (errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Power-on reset, outputs low meanwhile
    task automatic do_reset();
        srst = 1'b1;
        i_host.tick(10);
        check({6'h0, testResultOut, sdaOe}, 8'h00); // Outputs quiet in reset
        srst = 1'b0;
        i_host.tick(5);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Full pin run with the reset pin held low, then a restart
    task automatic test_pin_pass();
        logic hi;
        logic lo;
        selfCheckOk = 1'b1;
        ledPathOk = 5'b01101;
        activeLowResetPinN = 1'b0;
        i_host.tick(PWR_WAIT_CYC); // Settle after power-on
        i_host.pulse(hi, lo);
        check({7'h0, hi}, 8'h01); // Ack in time despite reset pin
        check({7'h0, lo}, 8'h00); // Low strobe, low result
        for (int n = 0; n < NUM_PATHS; n++) begin
            i_host.pulse(hi, lo);
            check({7'h0, hi}, {7'h0, ledPathOk[n]}); // Path outcome
            check({7'h0, lo}, 8'h00); // Low strobe, low result
        end
        i_host.pulse(hi, lo);
        check({7'h0, hi}, 8'h01); // Engine back at the ack step
        activeLowResetPinN = 1'b1;
    endtask

    // Failing self-check locks the result low
    task automatic test_pin_fail();
        logic hi;
        logic lo;
        selfCheckOk = 1'b0;
        do_reset();
        i_host.tick(PWR_WAIT_CYC);
        i_host.pulse(hi, lo);
        check({7'h0, hi}, 8'h00); // No ack on failure
        selfCheckOk = 1'b1;
        i_host.pulse(hi, lo);
        check({7'h0, hi}, 8'h00); // Still locked
    endtask

    // Field test through the control bus
    task automatic test_bus();
        logic [7:0] dat;
        logic [2:0] acks;
        do_reset();
        standbyReleaseBit = 1'b0;
        ledPathOk = 5'b10110;
        i_host.reg_write(BUS_TARGET_ADDR, REG_TEST_CMD_RES, TEST_START_CODE, acks);
        check({5'h0, acks}, 8'h00); // Every byte acknowledged
        i_host.reg_read(REG_TEST_CMD_RES, dat, acks);
        check(dat, RES_RESET); // Start ignored without both enables
        i_host.reg_write(BUS_TARGET_ADDR ^ 7'h01, REG_TEST_CMD_RES, TEST_START_CODE, acks);
        check({5'h0, acks}, 8'h07); // Other address not acknowledged
        standbyReleaseBit = 1'b1; // Host enables the device
        i_host.reg_write(BUS_TARGET_ADDR, REG_TEST_CMD_RES, TEST_START_CODE, acks);
        i_host.reg_read(REG_TEST_CMD_RES, dat, acks);
        check(dat, 8'h96); // Done and per-path pass
        check({5'h0, acks}, 8'h00); // Read cycle acknowledged
        ledPathOk = 5'b01001;
        activeLowResetPinN = 1'b0;
        i_host.tick(20);
        check({7'h0, sdaOe}, 8'h00); // Bus side held idle
        activeLowResetPinN = 1'b1;
        i_host.tick(20);
        i_host.reg_write(BUS_TARGET_ADDR, REG_TEST_CMD_RES, 8'h02, acks);
        i_host.reg_write(BUS_TARGET_ADDR, 8'h05, TEST_START_CODE, acks);
        i_host.reg_read(REG_TEST_CMD_RES, dat, acks);
        check(dat, 8'h96); // Result held across inputs and reset pin
        i_host.reg_read(8'h05, dat, acks);
        check(dat, READ_UNMAPPED); // Other index reads back empty
        i_host.reg_write(BUS_TARGET_ADDR, REG_TEST_CMD_RES, TEST_START_CODE, acks);
        i_host.reg_read(REG_TEST_CMD_RES, dat, acks);
        check(dat, 8'h89); // New start replaces the result
    endtask

    // Main sequence
    initial begin
        errors = 0;
        total_checks = 0;
        cycles = 0;
        srst = 1'b1;
        activeLowResetPinN = 1'b1;
        standbyReleaseBit = 1'b1;
        converterEnableBit = 1'b1;
        selfCheckOk = 1'b1;
        ledPathOk = '0;
        i_host.tick(10);
        srst = 1'b0;
        test_pin_pass();
        test_pin_fail();
        test_bus();
        print_verdict();
    end
endmodule
